// ===== vic_pkg.sv
// constants, register map and state encodings of the vectored interrupt controller
// Notes on behaviour
// - every interrupt branches to one common service address, not a per-source one
// - software trap ranks highest of all; the default dispatch entry ranks lowest
// - thirteen maskable inputs, each with a fixed rank and fixed vector slot
// - all but the trap are maskable; each has enable bit and pending flag set on event
// - pending raises interrupt only with its enable, global enable, and no trap service
// - requests are sampled only at the start of an instruction
// - a pending skip completes before any interrupt is acknowledged
// - among simultaneous eligible requests the highest rank wins, others stay pending
// - reset clears all pending flags, enable bits and the global enable
// - enabling a source whose flag is already set interrupts at once if global enable
// - acknowledge clears global enable, pushes next address, loads the service address
// - the acknowledge sequence takes seven instruction cycles
// - writing 1 to global enable in the status word allows nesting
// - return instruction sets global enable, pops address into the program counter
// - after return any still eligible request is serviced at once, by priority
// - pending flags and enable bits sit in readable and writable registers
// - boot ROM code blocks interrupts, global enable kept, resume on return
// - during self-programming repeat events of an already pending source are lost
// - dispatch uses highest enabled pending source, else the lowest default entry
package vic_pkg;
   localparam int NUM_SRC = 13;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int PC_W = 15;
   localparam int SLOT_W = 4;

   // register offsets
   localparam logic [7:0] OFS_ENABLE = 8'h00;
   localparam logic [7:0] OFS_PENDING = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;

   // status word bit positions
   localparam int STAT_GLOBAL_EN = 0;
   localparam int STAT_TRAP_BUSY = 1;
   localparam int STAT_TRAP_PEND = 2;
   localparam int STAT_ACK_BUSY = 3;
   localparam int STAT_BOOT = 4;

   // values after reset
   localparam logic [NUM_SRC-1:0] ENABLE_RST = 13'h0000;
   localparam logic [NUM_SRC-1:0] PENDING_RST = 13'h0000;
   localparam logic GLOB_EN_RST = 1'b0;

   // common service entry and vector table layout
   localparam logic [PC_W-1:0] SERVICE_ADDR = 15'h00FF;
   localparam logic [7:0] VEC_BASE = 8'hE0;
   localparam logic [SLOT_W-1:0] SLOT_TRAP = 4'hF;
   localparam logic [SLOT_W-1:0] SLOT_DEFAULT = 4'h0;
   // slot of the highest-ranked maskable input (index 0)
   localparam logic [SLOT_W-1:0] SLOT_TOP_MASKABLE = 4'hD;

   // acknowledge length in instruction cycles
   localparam logic [2:0] ACK_TC = 3'h7;

   typedef enum logic [1:0] {
      ST_RUN = 2'b01,
      ST_ACK = 2'b10
   } ack_state_t;
endpackage

// ===== vic_sync.sv
// two-flop synchroniser bank for the asynchronous request inputs
module vic_sync #(
   parameter int WIDTH = 13
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] stable_q;

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_ff @(posedge sys_clk or posedge reset) begin
            if (reset) begin
               meta_q[i] <= 1'b0;
               stable_q[i] <= 1'b0;
            end else begin
               meta_q[i] <= async_in[i];
               stable_q[i] <= meta_q[i];
            end
         end
      end
   endgenerate

   assign sync_out = stable_q;
endmodule

// ===== vic_prio.sv
// fixed-priority pick: the lowest index that is set wins
module vic_prio #(
   parameter int N = 13,
   parameter int IW = 4
) (
   input wire logic [N-1:0] req,
   output logic [IW-1:0] idx,
   output logic found
);
   // scanning downward lets the lowest set index overwrite the others
   always_comb begin
      idx = '0;
      found = 1'b0;
      for (int i = N - 1; i >= 0; i--) begin
         if (req[i]) begin
            idx = IW'(i);
            found = 1'b1;
         end
      end
   end
endmodule

// ===== vic_top.sv
// vectored interrupt controller facing the instruction sequencer and the register port
//
// The implementer's own choices: the strobed register port and the register offsets.
module vic_top #(
   parameter int NUM_SRC = vic_pkg::NUM_SRC
) (
   input wire logic sys_clk,
   input wire logic reset,
   // register port
   input wire logic [vic_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [vic_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [vic_pkg::DATA_W-1:0] reg_rdata,
   // interrupt conditions, asynchronous, rising edge is an event
   input wire logic [NUM_SRC-1:0] src_req,
   // instruction sequencer
   input wire logic instr_start,
   input wire logic skip_next,
   input wire logic tc_tick,
   input wire logic [vic_pkg::PC_W-1:0] ret_addr,
   input wire logic trap_instr,
   input wire logic return_from_int_instr,
   input wire logic vector_dispatch_instr,
   input wire logic boot_rom_active,
   input wire logic in_system_programming,
   output logic int_take,
   output logic ack_busy,
   output logic push_req,
   output logic [vic_pkg::PC_W-1:0] push_addr,
   output logic pc_load,
   output logic [vic_pkg::PC_W-1:0] pc_load_addr,
   output logic dispatch_valid,
   output logic [7:0] dispatch_vec_addr,
   output logic global_int_enable
);
   ////////////////////////////////////////////////////////////////////////////
   // state
   logic [NUM_SRC-1:0] enable_q;
   logic [NUM_SRC-1:0] enable_d;
   logic [NUM_SRC-1:0] pend_q;
   logic [NUM_SRC-1:0] pend_d;
   logic [NUM_SRC-1:0] src_prev_q;
   logic [NUM_SRC-1:0] src_sync;
   logic glob_en_q;
   logic glob_en_d;
   logic trap_pend_q;
   logic trap_pend_d;
   logic nmi_busy_q;
   logic nmi_busy_d;
   vic_pkg::ack_state_t state_q;
   vic_pkg::ack_state_t state_d;
   logic [2:0] tc_cnt_q;
   logic [2:0] tc_cnt_d;
   logic take_q;
   logic push_req_q;
   logic [vic_pkg::PC_W-1:0] push_addr_q;
   logic pc_load_q;
   logic [vic_pkg::PC_W-1:0] pc_load_addr_q;
   logic dispatch_valid_q;
   logic [7:0] dispatch_vec_addr_q;
   logic [vic_pkg::DATA_W-1:0] rdata_q;
   logic [vic_pkg::DATA_W-1:0] rdata_d;

   ////////////////////////////////////////////////////////////////////////////
   // request capture
   vic_sync #(
      .WIDTH(NUM_SRC)
   ) u_sync (
      .sys_clk(sys_clk),
      .reset(reset),
      .async_in(src_req),
      .sync_out(src_sync)
   );

   wire [NUM_SRC-1:0] src_rise = src_sync & ~src_prev_q;
   // while self-programming a repeat event of a pending source is dropped
   wire prog_drop = in_system_programming;
   wire [NUM_SRC-1:0] set_ok = src_rise & ~({NUM_SRC{prog_drop}} & pend_q);

   ////////////////////////////////////////////////////////////////////////////
   // register decode
   wire sel_enable = (reg_addr == vic_pkg::OFS_ENABLE);
   wire sel_pending = (reg_addr == vic_pkg::OFS_PENDING);
   wire sel_status = (reg_addr == vic_pkg::OFS_STATUS);
   wire wr_enable = reg_wr & sel_enable;
   wire wr_pending = reg_wr & sel_pending;
   wire wr_status = reg_wr & sel_status;

   wire [vic_pkg::DATA_W-1:0] status_word = vic_pkg::DATA_W'({
      boot_rom_active,
      (state_q == vic_pkg::ST_ACK),
      trap_pend_q,
      nmi_busy_q,
      glob_en_q
   });
   wire [vic_pkg::DATA_W-1:0] enable_word = vic_pkg::DATA_W'(enable_q);
   wire [vic_pkg::DATA_W-1:0] pend_word = vic_pkg::DATA_W'(pend_q);

   // unmapped addresses read as zero
   always_comb begin
      rdata_d = '0;
      if (reg_rd) begin
         if (sel_enable) begin
            rdata_d = enable_word;
         end else if (sel_pending) begin
            rdata_d = pend_word;
         end else if (sel_status) begin
            rdata_d = status_word;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // arbitration
   wire [NUM_SRC-1:0] active = pend_q & enable_q;
   // the boot ROM blocks only the take; global enable itself is untouched
   wire mask_ok = glob_en_q & ~nmi_busy_q & ~boot_rom_active;
   wire any_elig = (|active) & mask_ok;
   wire trap_req = trap_pend_q & ~nmi_busy_q & ~boot_rom_active;
   wire in_run = (state_q == vic_pkg::ST_RUN);
   // sampled only at an instruction start that is not being skipped
   wire take = in_run & instr_start & ~skip_next & (any_elig | trap_req);
   wire take_trap = take & trap_req;
   wire ack_last = (state_q == vic_pkg::ST_ACK) & tc_tick & (tc_cnt_q == vic_pkg::ACK_TC - 3'h1);

   logic [vic_pkg::SLOT_W-1:0] top_idx;
   logic top_found;
   vic_prio #(
      .N(NUM_SRC),
      .IW(vic_pkg::SLOT_W)
   ) u_prio (
      .req(active),
      .idx(top_idx),
      .found(top_found)
   );

   // fixed slot per input: index 0 owns the highest maskable slot
   wire [vic_pkg::SLOT_W-1:0] mask_slot = vic_pkg::SLOT_TOP_MASKABLE - top_idx;
   wire [vic_pkg::SLOT_W-1:0] disp_slot = trap_pend_q ? vic_pkg::SLOT_TRAP :
      (top_found ? mask_slot : vic_pkg::SLOT_DEFAULT);
   wire [7:0] disp_addr = vic_pkg::VEC_BASE + {3'h0, disp_slot, 1'b0};

   ////////////////////////////////////////////////////////////////////////////
   // next state of flags
   always_comb begin
      enable_d = enable_q;
      if (wr_enable) begin
         enable_d = reg_wdata[NUM_SRC-1:0];
      end
   end

   // hardware set wins over a software clear in the same cycle
   always_comb begin
      pend_d = pend_q;
      if (wr_pending) begin
         pend_d = reg_wdata[NUM_SRC-1:0];
      end
      pend_d = pend_d | set_ok;
   end

   // status write first, then return sets, then take clears and wins
   always_comb begin
      glob_en_d = glob_en_q;
      if (wr_status) begin
         glob_en_d = reg_wdata[vic_pkg::STAT_GLOBAL_EN];
      end
      if (return_from_int_instr) begin
         glob_en_d = 1'b1;
      end
      if (take) begin
         glob_en_d = 1'b0;
      end
   end

   // trap flag stays up through its service so dispatch still finds it
   always_comb begin
      trap_pend_d = trap_pend_q;
      nmi_busy_d = nmi_busy_q;
      if (take_trap) begin
         nmi_busy_d = 1'b1;
      end else if (return_from_int_instr & nmi_busy_q) begin
         nmi_busy_d = 1'b0;
         trap_pend_d = 1'b0;
      end
      if (trap_instr) begin
         trap_pend_d = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // acknowledge sequence
   always_comb begin
      state_d = state_q;
      tc_cnt_d = tc_cnt_q;
      case (state_q)
         vic_pkg::ST_RUN: begin
            tc_cnt_d = 3'h0;
            if (take) begin
               state_d = vic_pkg::ST_ACK;
            end
         end
         vic_pkg::ST_ACK: begin
            if (ack_last) begin
               state_d = vic_pkg::ST_RUN;
               tc_cnt_d = 3'h0;
            end else if (tc_tick) begin
               tc_cnt_d = tc_cnt_q + 3'h1;
            end
         end
         default: begin
            state_d = vic_pkg::ST_RUN;
            tc_cnt_d = 3'h0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // flip-flops
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         enable_q <= vic_pkg::ENABLE_RST;
         pend_q <= vic_pkg::PENDING_RST;
         glob_en_q <= vic_pkg::GLOB_EN_RST;
         src_prev_q <= '0;
      end else begin
         enable_q <= enable_d;
         pend_q <= pend_d;
         glob_en_q <= glob_en_d;
         src_prev_q <= src_sync;
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         trap_pend_q <= 1'b0;
         nmi_busy_q <= 1'b0;
         state_q <= vic_pkg::ST_RUN;
         tc_cnt_q <= 3'h0;
      end else begin
         trap_pend_q <= trap_pend_d;
         nmi_busy_q <= nmi_busy_d;
         state_q <= state_d;
         tc_cnt_q <= tc_cnt_d;
      end
   end

   // the sequencer pushes the address it was about to run
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         take_q <= 1'b0;
         push_req_q <= 1'b0;
         push_addr_q <= '0;
         pc_load_q <= 1'b0;
         pc_load_addr_q <= '0;
      end else begin
         take_q <= take;
         push_req_q <= take;
         if (take) begin
            push_addr_q <= ret_addr;
         end
         pc_load_q <= ack_last;
         pc_load_addr_q <= ack_last ? vic_pkg::SERVICE_ADDR : pc_load_addr_q;
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         dispatch_valid_q <= 1'b0;
         dispatch_vec_addr_q <= '0;
         rdata_q <= '0;
      end else begin
         dispatch_valid_q <= vector_dispatch_instr;
         if (vector_dispatch_instr) begin
            dispatch_vec_addr_q <= disp_addr;
         end
         rdata_q <= rdata_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   assign reg_rdata = rdata_q;
   assign int_take = take_q;
   assign ack_busy = state_q[1]; // one-hot acknowledge bit, straight from its flop
   assign push_req = push_req_q;
   assign push_addr = push_addr_q;
   assign pc_load = pc_load_q;
   assign pc_load_addr = pc_load_addr_q;
   assign dispatch_valid = dispatch_valid_q;
   assign dispatch_vec_addr = dispatch_vec_addr_q;
   assign global_int_enable = glob_en_q;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   AST_SERVICE_ADDR: assert property (
      @(posedge sys_clk) disable iff (reset)
      ack_last |=> pc_load && pc_load_addr == 15'h00FF)
      else $error("service address not loaded at end of acknowledge");

   logic [3:0] seen_ticks_q;
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         seen_ticks_q <= 4'h0;
      end else begin
         seen_ticks_q <= take ? 4'h0 : seen_ticks_q + {3'h0, ack_busy & tc_tick};
      end
   end

   AST_TRAP_TOP: assert property (
      @(posedge sys_clk) disable iff (reset)
      vector_dispatch_instr && trap_pend_q |=> dispatch_valid && dispatch_vec_addr == 8'hFE)
      else $error("trap not dispatched through top entry");

   AST_DEFAULT_ENTRY: assert property (
      @(posedge sys_clk) disable iff (reset)
      vector_dispatch_instr && !trap_pend_q && active == '0 |=> dispatch_vec_addr == 8'hE0)
      else $error("default entry not used with nothing pending");

   AST_TOP_SLOT: assert property (
      @(posedge sys_clk) disable iff (reset)
      vector_dispatch_instr && !trap_pend_q && active[0] |=> dispatch_vec_addr == 8'hFA)
      else $error("highest maskable source not chosen");

   AST_GATED: assert property (
      @(posedge sys_clk) disable iff (reset)
      take && !trap_req |-> glob_en_q && !nmi_busy_q && (active != '0))
      else $error("maskable take without its gating conditions");

   AST_BOUNDARY: assert property (
      @(posedge sys_clk) disable iff (reset)
      int_take |-> $past(instr_start) && !$past(skip_next))
      else $error("take outside a plain instruction start");

   AST_ACK_ENTRY: assert property (
      @(posedge sys_clk) disable iff (reset)
      take |=> !glob_en_q && push_req && push_addr == $past(ret_addr) && ack_busy)
      else $error("acknowledge entry actions missing");

   AST_ACK_LENGTH: assert property (
      @(posedge sys_clk) disable iff (reset)
      pc_load |-> seen_ticks_q == 4'h7)
      else $error("acknowledge did not end after seven instruction cycles");

   AST_RETURN_GLOB_EN: assert property (
      @(posedge sys_clk) disable iff (reset)
      return_from_int_instr && !take |=> glob_en_q)
      else $error("return did not set global enable");

   AST_BOOT_BLOCK: assert property (
      @(posedge sys_clk) disable iff (reset)
      boot_rom_active && !wr_status && !return_from_int_instr |=> !int_take && $stable(glob_en_q))
      else $error("interrupt taken from boot ROM");

   AST_EVENT_SETS: assert property (
      @(posedge sys_clk) disable iff (reset)
      src_rise != '0 && !in_system_programming |=> (pend_q & $past(src_rise)) == $past(src_rise))
      else $error("event lost against a clear");

   AST_IMMEDIATE: assert property (
      @(posedge sys_clk) disable iff (reset)
      in_run && instr_start && !skip_next && mask_ok && active != '0 |=> int_take)
      else $error("eligible request not taken at instruction start");
endmodule

// ===== seq_model.sv
// instruction sequencer model that feeds instruction starts, cycle ticks and return addresses
module seq_model (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic ack_busy,
   input wire logic int_take,
   input wire logic pc_load,
   input wire logic [vic_pkg::PC_W-1:0] pc_load_addr,
   input wire logic skip_en,
   output logic instr_start,
   output logic skip_next,
   output logic tc_tick,
   output logic [vic_pkg::PC_W-1:0] ret_addr,
   output logic [vic_pkg::PC_W-1:0] start_pc,
   output logic [3:0] tick_count
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] cyc_q;
   // one instruction every four clocks, one instruction cycle every two
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         cyc_q <= 2'h0;
         tc_tick <= 1'b0;
         instr_start <= 1'b0;
         skip_next <= 1'b0;
         ret_addr <= 15'h0100;
         start_pc <= 15'h0000;
         tick_count <= 4'h0;
      end else begin
         cyc_q <= cyc_q + 2'h1;
         tc_tick <= cyc_q[0];
         // no new instruction while the acknowledge owns the sequencer
         instr_start <= (cyc_q == 2'h3) && !ack_busy;
         skip_next <= skip_en;
         if (instr_start) begin
            start_pc <= ret_addr;
         end
         if (pc_load) begin
            ret_addr <= pc_load_addr;
         end else if (instr_start) begin
            ret_addr <= ret_addr + 15'h0001;
         end
         // ticks from the cycle after the take up to the jump
         if (int_take) begin
            tick_count <= {3'h0, tc_tick};
         end else if (ack_busy && tc_tick) begin
            tick_count <= tick_count + 4'h1;
         end
      end
   end
endmodule

// ===== testbench.sv
// self-checking bench for the interrupt controller with its sequencer model
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic [15:0] reg_rdata;
   logic [12:0] src_req = 13'h0000;
   logic trap = 1'b0, ret = 1'b0, disp = 1'b0, boot = 1'b0, selfprog = 1'b0, skip_en = 1'b0;
   logic instr_start, skip_next, tc_tick, int_take, ack_busy, push_req, pc_load, disp_valid, glob_en;
   logic [14:0] ret_addr, push_addr, pc_load_addr, start_pc;
   logic [7:0] disp_vec_addr;
   logic [3:0] tick_count;
   int n_errors = 0, cmp_count = 0, n_take = 0, i;

   initial begin
      forever #2.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      if (int_take === 1'b1) n_take++;
   end

   vic_top dut_u (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_req(src_req),
      .instr_start(instr_start), .skip_next(skip_next), .tc_tick(tc_tick), .ret_addr(ret_addr),
      .trap_instr(trap), .return_from_int_instr(ret), .vector_dispatch_instr(disp),
      .boot_rom_active(boot), .in_system_programming(selfprog), .int_take(int_take), .ack_busy(ack_busy),
      .push_req(push_req), .push_addr(push_addr), .pc_load(pc_load), .pc_load_addr(pc_load_addr),
      .dispatch_valid(disp_valid), .dispatch_vec_addr(disp_vec_addr), .global_int_enable(glob_en));
   seq_model seq_u (.sys_clk(sys_clk), .reset(reset), .ack_busy(ack_busy), .int_take(int_take),
      .pc_load(pc_load), .pc_load_addr(pc_load_addr), .skip_en(skip_en), .instr_start(instr_start),
      .skip_next(skip_next), .tc_tick(tc_tick), .ret_addr(ret_addr), .start_pc(start_pc),
      .tick_count(tick_count));

   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 chk("reg_rdata", reg_rdata, exp);
   endtask
   task automatic dispatch(input logic [7:0] exp);
      @(posedge sys_clk);
      disp <= 1'b1;
      @(posedge sys_clk);
      disp <= 1'b0;
      #1 chk("disp_valid", {15'h0000, disp_valid}, 16'h0001);
      chk("disp_vec_addr", {8'h00, disp_vec_addr}, {8'h00, exp});
   endtask
   task automatic pulse_ret();
      @(posedge sys_clk);
      ret <= 1'b1;
      @(posedge sys_clk);
      ret <= 1'b0;
   endtask
   // waits for one acknowledge and checks its push, length and target
   task automatic take_check();
      int k;
      for (k = 0; k < 40 && int_take !== 1'b1; k++) @(posedge sys_clk) #1;
      chk("int_take", {15'h0000, int_take}, 16'h0001);
      chk("push_req", {15'h0000, push_req}, 16'h0001);
      chk("ack_busy", {15'h0000, ack_busy}, 16'h0001);
      chk("push_addr", {1'b0, push_addr}, {1'b0, start_pc});
      chk("glob_en", {15'h0000, glob_en}, 16'h0000);
      for (k = 0; k < 40 && pc_load !== 1'b1; k++) @(posedge sys_clk) #1;
      chk("pc_load", {15'h0000, pc_load}, 16'h0001);
      chk("ack_busy", {15'h0000, ack_busy}, 16'h0000);
      chk("tick_count", {12'h000, tick_count}, 16'h0007);
      chk("pc_load_addr", {1'b0, pc_load_addr}, 16'h00FF);
   endtask
   task automatic no_take();
      int t;
      t = n_take;
      repeat (30) @(posedge sys_clk);
      chk("no take", 16'(n_take - t), 16'h0000);
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      #100us;
      n_errors++;
      end_of_test();
   end

   initial begin
      repeat (20) @(posedge sys_clk);
      reset <= 1'b0;
      rd(8'h00, 16'h0000);
      rd(8'h04, 16'h0000);
      rd(8'h08, 16'h0000);
      rd(8'h0C, 16'h0000);
      $display("test reset values done");
      for (i = 0; i < 13; i++) begin
         wr(8'h04, 16'(1 << i));
         wr(8'h00, 16'(1 << i));
         dispatch(8'(8'hE0 + 2 * (13 - i)));
      end
      wr(8'h04, 16'h0028);
      wr(8'h00, 16'h0028);
      dispatch(8'hF4);
      wr(8'h00, 16'h0000);
      dispatch(8'hE0);
      wr(8'h04, 16'h0000);
      $display("test dispatch done");
      @(posedge sys_clk);
      src_req <= 13'h0080;
      repeat (8) @(posedge sys_clk);
      rd(8'h04, 16'h0080);
      wr(8'h08, 16'h0001);
      no_take();
      wr(8'h00, 16'h0080);
      take_check();
      wr(8'h04, 16'h0084);
      wr(8'h00, 16'h0084);
      pulse_ret();
      take_check();
      dispatch(8'hF6);
      wr(8'h08, 16'h0001);
      take_check();
      wr(8'h00, 16'h0000);
      wr(8'h04, 16'h0000);
      $display("test maskable done");
      @(posedge sys_clk);
      trap <= 1'b1;
      @(posedge sys_clk);
      trap <= 1'b0;
      take_check();
      dispatch(8'hFE);
      wr(8'h04, 16'h0001);
      wr(8'h00, 16'h0001);
      wr(8'h08, 16'h0001);
      no_take();
      pulse_ret();
      take_check();
      $display("test trap done");
      wr(8'h00, 16'h0000);
      wr(8'h04, 16'h0002);
      boot <= 1'b1;
      wr(8'h00, 16'h0002);
      wr(8'h08, 16'h0001);
      no_take();
      rd(8'h08, 16'h0011);
      @(posedge sys_clk);
      skip_en <= 1'b1;
      @(posedge sys_clk);
      boot <= 1'b0;
      no_take();
      skip_en <= 1'b0;
      take_check();
      wr(8'h00, 16'h0000);
      pulse_ret();
      #1 chk("glob_en", {15'h0000, glob_en}, 16'h0001);
      $display("test boot and skip done");
      @(posedge sys_clk);
      selfprog <= 1'b1;
      src_req <= 13'h0086;
      repeat (5) @(posedge sys_clk);
      rd(8'h04, 16'h0006);
      wr(8'h04, 16'h0000);
      selfprog <= 1'b0;
      rd(8'h04, 16'h0000);
      $display("test self-programming done");
      end_of_test();
   end
endmodule
